// ### verilog/canmc_consts.vh
// canmc_consts.vh: offsets, field positions and reset values
// assumes: included by the configuration block, no processes here
`ifndef CANMC_CONSTS_VH
`define CANMC_CONSTS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CANMC_OFS_CONFIG 4'h0
`define CANMC_OFS_ERRCNT 4'h4
`define CANMC_OFS_LPCTRL 4'h8

// ---------------------------------------------------------------
// module_configuration field positions
// ---------------------------------------------------------------
`define CANMC_BIT_MODULE_DISABLE 0
`define CANMC_BIT_FRZ 1
`define CANMC_BIT_FEN 2
`define CANMC_BIT_HALT 3
`define CANMC_BIT_NRDY 4
`define CANMC_BIT_WAKM 5
`define CANMC_BIT_SRST 6
`define CANMC_BIT_FACK 7
`define CANMC_BIT_LACK 11
`define CANMC_MAXB_LO 16
`define CANMC_MAXB_HI 21

// ---------------------------------------------------------------
// low-power control field positions
// ---------------------------------------------------------------
`define CANMC_BIT_STOP 0
`define CANMC_BIT_PRUN 1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CANMC_RST_MODULE_DISABLE 1'b0
`define CANMC_RST_FRZ 1'b1
`define CANMC_RST_FEN 1'b0
`define CANMC_RST_HALT 1'b1
`define CANMC_RST_WAKM 1'b0
`define CANMC_RST_MAXB 6'h0F
`define CANMC_RST_ERRCNT 16'h0000

// ---------------------------------------------------------------
// soft reset states
// ---------------------------------------------------------------
`define CANMC_SR_IDLE 2'b00
`define CANMC_SR_WAIT 2'b01
`define CANMC_SR_DONE 2'b10

`endif

// ### verilog/canmc_top.v
// canmc_top.v: mode and configuration control of a CAN controller
// assumes: Avalon-MM master on clk_i, protocol engine on clk_i,
// chip-level debug, soft reset and stop requests arrive as pins
//
// How it works
// - disable bit gates protocol and buffer manager clocks off
// - soft reset keeps the disable bit as it was
// - freeze entry needs freeze-enable; halt or debug alone does not freeze
// - clearing freeze-enable while frozen leaves freeze mode
// - fifo-enable hands buffers 0 to 7 region to the receive fifo
// - halt bit requests freeze, honoured only with freeze-enable set
// - no frame sent or received while halt stays set
// - error counter writable only in freeze, read-only otherwise
// - no freeze entry while in any low-power mode
// - not-ready reads 1 in disable, stop or freeze, else 0
// - wake-up mask gates the wake-up interrupt
// - soft reset clears state and listed registers except disable
// - soft reset spares bus control, rx masks, buffer contents
// - soft reset set by software write or chip soft reset
// - soft-reset bit stays set while pending, clears when done
// - soft reset runs by request and acknowledge handshake
// - freeze ack after transfers end and prescaler stops
// - low-power ack in disable or stop, after transfers end
`timescale 1ns/1ps
`include "canmc_consts.vh"

module canmc_sync
(
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // pin in, filtered level out
    input wire d_i,
    output reg q_o
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q_o <= 1'b0;
        end
        else
        begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                q_o <= s3;
        end
    end
endmodule // canmc_sync

module canmc_top
(
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // avalon-mm slave
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // chip-level requests (pins)
    input wire debug_req_i,
    input wire global_soft_rst_i,
    input wire stop_req_i,
    // protocol engine status
    input wire xfer_busy_i,
    input wire wakeup_event_i,
    // engine and submodule controls
    output reg proto_clk_en_o,
    output reg mbm_clk_en_o,
    output reg frame_en_o,
    output reg rx_fifo_enable_o,
    output reg [5:0] max_buffer_count_o,
    output reg freeze_o,
    output reg soft_rst_o,
    output reg wakeup_irq_o
);
    // -----------------------------------------------------------
    // declarations
    // -----------------------------------------------------------
    reg module_disable;
    reg freeze_enable;
    reg rx_fifo_enable;
    reg halt;
    reg wakeup_irq_enable;
    reg soft_rst_bit;
    reg [5:0] max_buffer_count;
    reg freeze_acknowledge;
    reg low_power_acknowledge;
    reg prescaler_run;
    reg [15:0] error_counter;
    reg [1:0] sr_state;
    reg sr_req_tgl;
    reg sr_ack_tgl;
    reg sr_req_s1;
    reg sr_req_s2;
    reg sr_ack_s1;
    reg sr_ack_s2;
    reg gsr_seen;
    wire debug_req;
    wire global_soft_rst;
    wire stop_req;
    wire acc_done;
    wire wr_cfg;
    wire wr_err;
    wire freeze_req;
    wire low_power;
    wire sr_complete;
    wire gsr_rise;
    wire not_ready;
    wire [31:0] cfg_word;

    // -----------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------
    canmc_sync u_sync_dbg
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(debug_req_i),
        .q_o(debug_req)
    );

    canmc_sync u_sync_gsr
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(global_soft_rst_i),
        .q_o(global_soft_rst)
    );

    canmc_sync u_sync_stop
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(stop_req_i),
        .q_o(stop_req)
    );

    // -----------------------------------------------------------
    // bus decode
    // -----------------------------------------------------------
    assign acc_done = !avs_waitrequest_o;
    assign wr_cfg = avs_write_i && acc_done &&
        (avs_address_i == `CANMC_OFS_CONFIG) && avs_byteenable_i[0];
    assign wr_err = avs_write_i && acc_done &&
        (avs_address_i == `CANMC_OFS_ERRCNT) &&
        freeze_acknowledge;

    // -----------------------------------------------------------
    // mode decode
    // -----------------------------------------------------------
    assign low_power = module_disable || stop_req;
    assign freeze_req = freeze_enable &&
        (halt || debug_req);
    assign not_ready = low_power_acknowledge ||
        freeze_acknowledge;
    assign gsr_rise = global_soft_rst && !gsr_seen;
    assign sr_complete = (sr_state == `CANMC_SR_DONE);

    assign cfg_word = {10'h000,
        max_buffer_count,
        4'h0,
        low_power_acknowledge,
        3'h0,
        freeze_acknowledge,
        soft_rst_bit,
        wakeup_irq_enable,
        not_ready,
        halt,
        rx_fifo_enable,
        freeze_enable,
        module_disable};

    // -----------------------------------------------------------
    // avalon slave timing
    // -----------------------------------------------------------
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
        end
        else
        begin
            if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
                avs_waitrequest_o <= 1'b0;
            else
                avs_waitrequest_o <= 1'b1;
            if (avs_read_i && avs_waitrequest_o)
            begin
                if (avs_address_i == `CANMC_OFS_CONFIG)
                    avs_readdata_o <= cfg_word;
                else if (avs_address_i == `CANMC_OFS_ERRCNT)
                    avs_readdata_o <= {16'h0000, error_counter};
                else if (avs_address_i == `CANMC_OFS_LPCTRL)
                    avs_readdata_o <= {30'h0000_0000, prescaler_run,
                        stop_req};
                else
                    avs_readdata_o <= 32'h0000_0000;
            end
        end
    end

    // -----------------------------------------------------------
    // configuration register
    // -----------------------------------------------------------
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            module_disable <= `CANMC_RST_MODULE_DISABLE;
            freeze_enable <= `CANMC_RST_FRZ;
            rx_fifo_enable <= `CANMC_RST_FEN;
            halt <= `CANMC_RST_HALT;
            wakeup_irq_enable <= `CANMC_RST_WAKM;
            max_buffer_count <= `CANMC_RST_MAXB;
            error_counter <= `CANMC_RST_ERRCNT;
        end
        else if (sr_complete)
        begin
            // module_disable kept here
            freeze_enable <= `CANMC_RST_FRZ;
            rx_fifo_enable <= `CANMC_RST_FEN;
            halt <= `CANMC_RST_HALT;
            wakeup_irq_enable <= `CANMC_RST_WAKM;
            max_buffer_count <= `CANMC_RST_MAXB;
            error_counter <= `CANMC_RST_ERRCNT;
        end
        else
        begin
            if (wr_cfg)
            begin
                module_disable <= avs_writedata_i[`CANMC_BIT_MODULE_DISABLE];
                freeze_enable <= avs_writedata_i[`CANMC_BIT_FRZ];
                rx_fifo_enable <= avs_writedata_i[`CANMC_BIT_FEN];
                halt <= avs_writedata_i[`CANMC_BIT_HALT];
                wakeup_irq_enable <= avs_writedata_i[`CANMC_BIT_WAKM];
            end
            if (avs_write_i && acc_done && avs_byteenable_i[2] &&
                (avs_address_i == `CANMC_OFS_CONFIG))
                max_buffer_count <=
                    avs_writedata_i[`CANMC_MAXB_HI:`CANMC_MAXB_LO];
            if (wr_err)
            begin
                if (avs_byteenable_i[0])
                    error_counter[7:0] <= avs_writedata_i[7:0];
                if (avs_byteenable_i[1])
                    error_counter[15:8] <= avs_writedata_i[15:8];
            end
        end
    end

    // -----------------------------------------------------------
    // freeze and low-power acknowledge
    // -----------------------------------------------------------
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prescaler_run <= 1'b1;
            freeze_acknowledge <= 1'b0;
            low_power_acknowledge <= 1'b0;
        end
        else
        begin
            // stop prescaler once idle
            if (freeze_req && !low_power && !xfer_busy_i)
                prescaler_run <= 1'b0;
            else if (!freeze_req)
                prescaler_run <= 1'b1;
            if (!prescaler_run && freeze_req && !low_power)
                freeze_acknowledge <= 1'b1;
            else if (prescaler_run || low_power)
                freeze_acknowledge <= 1'b0;
            if (low_power && !xfer_busy_i)
                low_power_acknowledge <= 1'b1;
            else if (!low_power)
                low_power_acknowledge <= 1'b0;
        end
    end

    // -----------------------------------------------------------
    // soft reset handshake
    // -----------------------------------------------------------
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            soft_rst_bit <= 1'b0;
            gsr_seen <= 1'b0;
            sr_state <= `CANMC_SR_IDLE;
            sr_req_tgl <= 1'b0;
            sr_ack_tgl <= 1'b0;
            sr_req_s1 <= 1'b0;
            sr_req_s2 <= 1'b0;
            sr_ack_s1 <= 1'b0;
            sr_ack_s2 <= 1'b0;
            soft_rst_o <= 1'b0;
        end
        else
        begin
            gsr_seen <= global_soft_rst;
            // engine side echoes the request toggle
            sr_req_s1 <= sr_req_tgl;
            sr_req_s2 <= sr_req_s1;
            sr_ack_tgl <= sr_req_s2;
            soft_rst_o <= (sr_req_s2 != sr_ack_tgl);
            sr_ack_s1 <= sr_ack_tgl;
            sr_ack_s2 <= sr_ack_s1;
            // set wins over the self-clear
            if ((wr_cfg && avs_writedata_i[`CANMC_BIT_SRST]) ||
                gsr_rise)
                soft_rst_bit <= 1'b1;
            else if (sr_complete)
                soft_rst_bit <= 1'b0;
            case (sr_state)
                `CANMC_SR_IDLE:
                begin
                    if (soft_rst_bit)
                    begin
                        sr_req_tgl <= !sr_req_tgl;
                        sr_state <= `CANMC_SR_WAIT;
                    end
                end
                `CANMC_SR_WAIT:
                begin
                    if (sr_ack_s2 == sr_req_tgl)
                        sr_state <= `CANMC_SR_DONE;
                end
                `CANMC_SR_DONE:
                begin
                    sr_state <= `CANMC_SR_IDLE;
                end
                default:
                begin
                    sr_state <= `CANMC_SR_IDLE;
                end
            endcase
        end
    end

    // -----------------------------------------------------------
    // registered outputs
    // -----------------------------------------------------------
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            proto_clk_en_o <= 1'b1;
            mbm_clk_en_o <= 1'b1;
            frame_en_o <= 1'b0;
            rx_fifo_enable_o <= 1'b0;
            max_buffer_count_o <= `CANMC_RST_MAXB;
            freeze_o <= 1'b0;
            wakeup_irq_o <= 1'b0;
        end
        else
        begin
            proto_clk_en_o <= !low_power_acknowledge;
            mbm_clk_en_o <= !low_power_acknowledge;
            frame_en_o <= !halt && !not_ready && prescaler_run &&
                !soft_rst_bit;
            rx_fifo_enable_o <= rx_fifo_enable;
            max_buffer_count_o <= max_buffer_count;
            freeze_o <= freeze_acknowledge;
            wakeup_irq_o <= wakeup_event_i &&
                wakeup_irq_enable;
        end
    end

endmodule // canmc_top

// ### verification/canmc_sva.sv
// canmc_sva.sv: port-level checks of the mode and configuration block
// assumes: bound into canmc_top, one clock domain on clk_i
`timescale 1ns/1ps

module canmc_sva
(
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // bus handshake
    input wire avs_read_i,
    input wire avs_write_i,
    input wire avs_waitrequest_o,
    // engine status
    input wire xfer_busy_i,
    input wire wakeup_event_i,
    // controls out
    input wire proto_clk_en_o,
    input wire mbm_clk_en_o,
    input wire frame_en_o,
    input wire freeze_o,
    input wire soft_rst_o,
    input wire wakeup_irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ---------------------------------------------------------------
    // sequences
    // ---------------------------------------------------------------
    sequence s_ack;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    sequence s_frozen;
        freeze_o [*2];
    endsequence

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_wait_single: assert property ($fell(avs_waitrequest_o) |-> s_ack)
        else $error("waitrequest low for more than one cycle");
    a_wait_cause: assert property ($fell(avs_waitrequest_o)
        |-> $past(avs_read_i || avs_write_i))
        else $error("waitrequest dropped without a request");
    a_clk_pair: assert property (proto_clk_en_o == mbm_clk_en_o)
        else $error("submodule clock enables differ");
    a_frozen_quiet: assert property (s_frozen |-> !frame_en_o)
        else $error("frames enabled while frozen");
    a_lowpower_quiet: assert property
        (!proto_clk_en_o [*2] |-> !frame_en_o)
        else $error("frames enabled with clocks gated");
    a_wake_cause: assert property
        (wakeup_irq_o |-> $past(wakeup_event_i))
        else $error("wake interrupt without wake event");
    a_srst_pulse: assert property (soft_rst_o |=> !soft_rst_o)
        else $error("soft reset pulse longer than one cycle");
    a_freeze_idle: assert property
        ($rose(freeze_o) |-> $past(!xfer_busy_i))
        else $error("freeze acknowledged during a transfer");
endmodule // canmc_sva

bind canmc_top canmc_sva u_sva
(
    .clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o),
    .xfer_busy_i(xfer_busy_i), .wakeup_event_i(wakeup_event_i),
    .proto_clk_en_o(proto_clk_en_o), .mbm_clk_en_o(mbm_clk_en_o),
    .frame_en_o(frame_en_o), .freeze_o(freeze_o),
    .soft_rst_o(soft_rst_o), .wakeup_irq_o(wakeup_irq_o)
);

// ### verification/test_can_module_mode_config.sv
// test_can_module_mode_config.sv: self-checking bench for canmc_top
// assumes: design and checker compiled first, verilog/ on include path
`timescale 1ns/1ps
`include "canmc_consts.vh"

module test_can_module_mode_config;
    localparam [3:0] CFG = `CANMC_OFS_CONFIG;
    localparam [3:0] ERR = `CANMC_OFS_ERRCNT;
    reg clk_i = 1'h0;
    reg rst_n_i = 1'h0;
    reg [3:0] avs_address_i = 4'h0;
    reg avs_read_i = 1'h0;
    reg avs_write_i = 1'h0;
    reg [31:0] avs_writedata_i = 32'h0;
    reg [3:0] avs_byteenable_i = 4'hF;
    reg debug_req_i = 1'h0;
    reg global_soft_rst_i = 1'h0;
    reg stop_req_i = 1'h0;
    reg xfer_busy_i = 1'h0;
    reg wakeup_event_i = 1'h0;
    wire [31:0] avs_readdata_o;
    wire [5:0] max_buffer_count_o;
    wire avs_waitrequest_o, proto_clk_en_o, mbm_clk_en_o, frame_en_o;
    wire rx_fifo_enable_o, freeze_o, soft_rst_o, wakeup_irq_o;
    integer n_mismatch = 0;
    integer compares = 0;
    integer cycles = 0;
    integer n_srst = 0;
    reg [31:0] rd;

    canmc_top DUT
    (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .debug_req_i(debug_req_i),
        .global_soft_rst_i(global_soft_rst_i), .stop_req_i(stop_req_i),
        .xfer_busy_i(xfer_busy_i), .wakeup_event_i(wakeup_event_i),
        .proto_clk_en_o(proto_clk_en_o), .mbm_clk_en_o(mbm_clk_en_o),
        .frame_en_o(frame_en_o), .rx_fifo_enable_o(rx_fifo_enable_o),
        .max_buffer_count_o(max_buffer_count_o), .freeze_o(freeze_o),
        .soft_rst_o(soft_rst_o), .wakeup_irq_o(wakeup_irq_o)
    );

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (soft_rst_o === 1'h1)
            n_srst = n_srst + 1;
        if (cycles == 4000)
        begin
            n_mismatch = n_mismatch + 1;
            end_of_test;
        end
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task end_of_test;
        begin
            $display("mismatches %0d compares %0d", n_mismatch, compares);
            if (n_mismatch == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task check(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task bus(input wr, input [3:0] a, input [31:0] d, input [3:0] be);
        begin
            avs_address_i <= a;
            avs_writedata_i <= d;
            avs_byteenable_i <= be;
            avs_read_i <= !wr;
            avs_write_i <= wr;
            @(posedge clk_i);
            while (avs_waitrequest_o !== 1'h0)
                @(posedge clk_i);
            rd = avs_readdata_o;
            avs_read_i <= 1'h0;
            avs_write_i <= 1'h0;
            @(posedge clk_i);
        end
    endtask

    task poll(input [31:0] m, input [31:0] v);
        integer i;
        begin
            i = 0;
            bus(0, CFG, 32'h0, 4'hF);
            while ((rd & m) !== v && i < 20)
            begin
                bus(0, CFG, 32'h0, 4'hF);
                i = i + 1;
            end
            check(rd & m, v);
        end
    endtask

    task wake(input e);
        begin
            wakeup_event_i <= 1'h1;
            @(posedge clk_i);
            wakeup_event_i <= 1'h0;
            @(negedge clk_i);
            check(wakeup_irq_o, e);
            @(posedge clk_i);
        end
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task t_reset;
        begin
            poll(32'h80, 32'h80);
            check(rd, 32'h000F009A);
            check({frame_en_o, freeze_o}, 2'h1);
            bus(1, CFG, 32'h0000000A, 4'h1);
            bus(0, CFG, 32'h0, 4'hF);
            check(rd, 32'h000F009A);
            bus(0, 4'hC, 32'h0, 4'hF);
            check(rd, 32'h0);
        end
    endtask

    task t_errcnt;
        begin
            bus(1, ERR, 32'h00001234, 4'h3);
            bus(0, ERR, 32'h0, 4'hF);
            check(rd, 32'h00001234);
            bus(1, CFG, 32'h02, 4'h1);
            poll(32'h90, 32'h00);
            check(frame_en_o, 1'h1);
            bus(1, ERR, 32'h00005555, 4'h3);
            bus(0, ERR, 32'h0, 4'hF);
            check(rd, 32'h00001234);
        end
    endtask

    task t_freeze_en;
        begin
            debug_req_i <= 1'h1;
            bus(1, CFG, 32'h08, 4'h1);
            repeat (6) bus(0, CFG, 32'h0, 4'hF);
            check(rd & 32'h90, 32'h0);
            check(frame_en_o, 1'h0);
            bus(1, CFG, 32'h02, 4'h1);
            poll(32'h90, 32'h90);
            bus(1, CFG, 32'h00, 4'h1);
            poll(32'h90, 32'h00);
            debug_req_i <= 1'h0;
        end
    endtask

    task t_busy;
        begin
            xfer_busy_i <= 1'h1;
            bus(1, CFG, 32'h0A, 4'h1);
            repeat (4) bus(0, CFG, 32'h0, 4'hF);
            check(rd & 32'h80, 32'h0);
            xfer_busy_i <= 1'h0;
            poll(32'h80, 32'h80);
            bus(1, CFG, 32'h02, 4'h1);
            poll(32'h90, 32'h00);
        end
    endtask

    task t_low_power;
        begin
            bus(1, CFG, 32'h03, 4'h1);
            poll(32'h810, 32'h810);
            check({proto_clk_en_o, mbm_clk_en_o}, 2'h0);
            bus(1, CFG, 32'h0B, 4'h1);
            repeat (3) bus(0, CFG, 32'h0, 4'hF);
            check(rd & 32'h80, 32'h0);
            bus(1, CFG, 32'h0A, 4'h1);
            poll(32'h880, 32'h080);
            check({proto_clk_en_o, mbm_clk_en_o}, 2'h3);
            stop_req_i <= 1'h1;
            poll(32'h810, 32'h810);
            stop_req_i <= 1'h0;
            poll(32'h800, 32'h000);
            bus(1, CFG, 32'h02, 4'h1);
            poll(32'h90, 32'h00);
        end
    endtask

    task t_fifo_wake;
        begin
            bus(1, CFG, 32'h26, 4'h1);
            wake(1'h1);
            check(rx_fifo_enable_o, 1'h1);
            bus(1, CFG, 32'h06, 4'h1);
            wake(1'h0);
        end
    endtask

    task t_srst;
        begin
            bus(1, CFG, 32'h2E, 4'h1);
            poll(32'h80, 32'h80);
            bus(1, CFG, 32'h00200000, 4'h4);
            bus(1, ERR, 32'h000000AB, 4'h3);
            bus(0, CFG, 32'h0, 4'hF);
            check(max_buffer_count_o, 6'h20);
            n_srst = 0;
            bus(1, CFG, 32'h6E, 4'h1);
            bus(0, CFG, 32'h0, 4'hF);
            check(rd & 32'h40, 32'h40);
            poll(32'h40, 32'h00);
            poll(32'h80, 32'h80);
            check(rd, 32'h000F009A);
            check(max_buffer_count_o, 6'h0F);
            check(n_srst, 1);
            bus(0, ERR, 32'h0, 4'hF);
            check(rd, 32'h0);
            global_soft_rst_i <= 1'h1;
            poll(32'h40, 32'h40);
            global_soft_rst_i <= 1'h0;
            poll(32'h40, 32'h00);
            check(n_srst, 2);
        end
    endtask

    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'h1;
        @(posedge clk_i);
        t_reset;
        t_errcnt;
        t_freeze_en;
        t_busy;
        t_low_power;
        t_fifo_wake;
        t_srst;
        end_of_test;
    end
endmodule // test_can_module_mode_config
